// File: rtl/tdm_regs.svh
/*
 Register indices, field positions and reset values of the amplitude flag, dwell
 and signal monitor block. Assumes APB byte addresses equal four times an index.
*/
// Behaviour
// - A 13-bit lower flag threshold is built from an 8-bit low byte and a 5-bit high field and compared with the fine sample magnitude.
// - A 16-bit dwell value, written as low and high bytes, is the load value of the dwell counter.
// - The flag pins return to 0 only after the magnitude stayed below the lower threshold for the dwell count.
// - With next-sync mode 0 the monitor realigns on every rising SYSREF edge while the SYSREF receiver bit is 1; with 1 only the next valid rising edge realigns it.
// - Sync enable 0 disables monitor sync; in next-sync mode the enable clears itself once a SYSREF edge is taken.
// - Bit 1 of the monitor control register disables the peak detector at 0 and enables it at 1.
// - A 13-bit upper threshold, low byte plus 5-bit high field, is compared with the fine sample magnitude.
// - The flag output is active only while its enable bit is 1, and a force bit replaces the pin with a force value.
// - The monitor runs over a 24-bit period in clock cycles, odd or even, that resets to 128.
`ifndef TDM_REGS_SVH
`define TDM_REGS_SVH

`define TDM_IDX_FLAG_CTRL 10'h245
`define TDM_IDX_UP_LOW 10'h247
`define TDM_IDX_UP_HIGH 10'h248
`define TDM_IDX_LOW_LOW 10'h249
`define TDM_IDX_LOW_HIGH 10'h24A
`define TDM_IDX_DWELL_LOW 10'h24B
`define TDM_IDX_DWELL_HIGH 10'h24C
`define TDM_IDX_SYNC_CTRL 10'h26F
`define TDM_IDX_MON_CTRL 10'h270
`define TDM_IDX_PERIOD0 10'h271
`define TDM_IDX_PERIOD1 10'h272
`define TDM_IDX_PERIOD2 10'h273
`define TDM_IDX_STATUS 10'h280
`define TDM_IDX_IRQ_STAT 10'h281
`define TDM_IDX_IRQ_MASK 10'h282
`define TDM_IDX_SYSREF_RX 10'h283
`define TDM_IDX_PEAK 10'h284

`define TDM_FC_EN 0
`define TDM_FC_FORCE_VAL 2
`define TDM_FC_FORCE_EN 3
`define TDM_SC_EN 0
`define TDM_SC_NEXT 1
`define TDM_MC_PEAK_EN 1
`define TDM_EV_RISE 0
`define TDM_EV_FALL 1
`define TDM_EV_SYNC 2
`define TDM_EV_PERIOD 3

`define TDM_THR_RST 13'h0000
`define TDM_DWELL_RST 16'h0000
`define TDM_PERIOD_RST 24'h000080
`define TDM_IRQ_RST 4'h0

`endif

// File: rtl/tdm_pkg.sv
/*
 Types of the flag and monitor block: the state records of both modules.
 Assumes the constants header is included by every user.
*/
package tdm_pkg;

    typedef struct packed {
        logic flag;
        logic [15:0] cnt;
        logic rise;
        logic fall;
    } tdm_flag_state_t;

    typedef struct packed {
        logic [12:0] upThr;
        logic [12:0] lowThr;
        logic [15:0] dwell;
        logic flagEn;
        logic forceEn;
        logic forceVal;
        logic syncEn;
        logic syncNext;
        logic peakEn;
        logic rxEn;
        logic [23:0] period;
        logic [23:0] periodCnt;
        logic [12:0] peak;
        logic [12:0] peakResult;
        logic [3:0] irqStat;
        logic [3:0] irqMask;
        logic sys1;
        logic sys2;
        logic sysPrev;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic pinFirst;
        logic pinSecond;
        logic irq;
    } tdm_top_state_t;

endpackage : tdm_pkg

// File: rtl/tdm_flag_if.sv
/*
 Carrier between the register block and the flag engine.
 Assumes both ends run on the same clock.
*/
interface tdm_flag_if;
    logic [12:0] upper;
    logic [12:0] lower;
    logic [15:0] dwell;
    logic [12:0] mag;
    logic flag;
    logic rise;
    logic fall;

    modport ctrl (output upper, output lower, output dwell, output mag,
                  input flag, input rise, input fall);
    modport engine (input upper, input lower, input dwell, input mag,
                    output flag, output rise, output fall);
endinterface : tdm_flag_if

// File: rtl/tdm_flag_engine.sv
/*
 Amplitude flag engine: sets above the upper threshold, releases after a dwell
 below the lower one. Assumes magnitude and thresholds are on clk.
*/
`include "tdm_regs.svh"

module tdm_flag_engine
    import tdm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    tdm_flag_if.engine ifc
);
    tdm_flag_state_t s_r;
    tdm_flag_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rise = 1'b0;
        s_nxt.fall = 1'b0;
        if (ifc.mag > ifc.upper) begin
            s_nxt.flag = 1'b1;
            s_nxt.cnt = ifc.dwell;
            s_nxt.rise = ~s_r.flag;
        end else if (ifc.mag >= ifc.lower) begin
            s_nxt.cnt = ifc.dwell;
        end else if (s_r.flag) begin
            // A dwell of 0 or 1 releases after one cycle below
            if (s_r.cnt <= 16'h0001) begin
                s_nxt.flag = 1'b0;
                s_nxt.cnt = 16'h0000;
                s_nxt.fall = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ifc.flag = s_r.flag;
    assign ifc.rise = s_r.rise;
    assign ifc.fall = s_r.fall;

    a_flag_set: assert property (@(posedge clk) disable iff (reset)
        ifc.mag > ifc.upper |=> s_r.flag)
        else $error("flag not set above upper threshold");

    a_dwell_load: assert property (@(posedge clk) disable iff (reset)
        ifc.mag >= ifc.lower |=> s_r.cnt == $past(ifc.dwell))
        else $error("dwell not reloaded at or above lower threshold");

    // Upper below lower is legal to program, so the set branch is excluded
    a_dwell_count: assert property (@(posedge clk) disable iff (reset)
        s_r.flag && ifc.mag < ifc.lower && ifc.mag <= ifc.upper && s_r.cnt > 16'h0001
        |=> s_r.flag && s_r.cnt == $past(s_r.cnt) - 16'h0001)
        else $error("dwell did not count down by one");

    a_flag_release: assert property (@(posedge clk) disable iff (reset)
        s_r.flag && ifc.mag < ifc.lower && ifc.mag <= ifc.upper && s_r.cnt <= 16'h0001
        |=> !s_r.flag && s_r.fall)
        else $error("flag not released at end of dwell");

endmodule : tdm_flag_engine

// File: rtl/tdm_monitor_top.sv
/*
 APB register block for the amplitude flag pins, dwell, monitor period,
 SYSREF sync and peak detector, with a masked interrupt.
 Assumes sampleMag is on clk and sysrefIn is an asynchronous pin.
*/
// Chosen here: register access over APB.
`include "tdm_regs.svh"

module tdm_monitor_top
    import tdm_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [12:0] sampleMag,
    input wire logic sysrefIn,
    output logic amplitudeFlagPinFirst,
    output logic amplitudeFlagPinSecond,
    output logic irq
);
    tdm_top_state_t s_r;
    tdm_top_state_t s_nxt;
    tdm_flag_if flagIf ();

    logic access;
    logic wr;
    logic [9:0] idx;

    assign access = psel & penable & ~s_r.ready;
    assign wr = psel & penable & s_r.ready & pwrite;
    assign idx = paddr[11:2];

    tdm_flag_engine tdm_flag_engine_inst (
        .clk(clk),
        .reset(reset),
        .ifc(flagIf)
    );

    assign flagIf.upper = s_r.upThr;
    assign flagIf.lower = s_r.lowThr;
    assign flagIf.dwell = s_r.dwell;
    assign flagIf.mag = sampleMag;

    always_comb begin
        logic [31:0] rd;
        logic hit;
        logic [3:0] clr;
        logic [3:0] ev;
        logic edgeSeen;
        rd = 32'h00000000;
        hit = 1'b1;
        clr = 4'h0;
        ev = 4'h0;
        edgeSeen = s_r.sys2 & ~s_r.sysPrev;
        s_nxt = s_r;

        // Address decode: writes land at the edge that completes the access
        if (idx == `TDM_IDX_FLAG_CTRL) begin
            rd = {28'h0000000, s_r.forceEn, s_r.forceVal, 1'b0, s_r.flagEn};
            if (wr) begin
                s_nxt.forceEn = pwdata[`TDM_FC_FORCE_EN];
                s_nxt.forceVal = pwdata[`TDM_FC_FORCE_VAL];
                s_nxt.flagEn = pwdata[`TDM_FC_EN];
            end
        end else if (idx == `TDM_IDX_UP_LOW) begin
            rd = {24'h000000, s_r.upThr[7:0]};
            if (wr) begin
                s_nxt.upThr[7:0] = pwdata[7:0];
            end
        end else if (idx == `TDM_IDX_UP_HIGH) begin
            rd = {27'h0000000, s_r.upThr[12:8]};
            if (wr) begin
                s_nxt.upThr[12:8] = pwdata[4:0];
            end
        end else if (idx == `TDM_IDX_LOW_LOW) begin
            rd = {24'h000000, s_r.lowThr[7:0]};
            if (wr) begin
                s_nxt.lowThr[7:0] = pwdata[7:0];
            end
        end else if (idx == `TDM_IDX_LOW_HIGH) begin
            rd = {27'h0000000, s_r.lowThr[12:8]};
            if (wr) begin
                s_nxt.lowThr[12:8] = pwdata[4:0];
            end
        end else if (idx == `TDM_IDX_DWELL_LOW) begin
            rd = {24'h000000, s_r.dwell[7:0]};
            if (wr) begin
                s_nxt.dwell[7:0] = pwdata[7:0];
            end
        end else if (idx == `TDM_IDX_DWELL_HIGH) begin
            rd = {24'h000000, s_r.dwell[15:8]};
            if (wr) begin
                s_nxt.dwell[15:8] = pwdata[7:0];
            end
        end else if (idx == `TDM_IDX_SYNC_CTRL) begin
            rd = {30'h00000000, s_r.syncNext, s_r.syncEn};
            if (wr) begin
                s_nxt.syncNext = pwdata[`TDM_SC_NEXT];
                s_nxt.syncEn = pwdata[`TDM_SC_EN];
            end
        end else if (idx == `TDM_IDX_MON_CTRL) begin
            rd = {30'h00000000, s_r.peakEn, 1'b0};
            if (wr) begin
                s_nxt.peakEn = pwdata[`TDM_MC_PEAK_EN];
            end
        end else if (idx == `TDM_IDX_PERIOD0) begin
            rd = {24'h000000, s_r.period[7:0]};
            if (wr) begin
                s_nxt.period[7:0] = pwdata[7:0];
            end
        end else if (idx == `TDM_IDX_PERIOD1) begin
            rd = {24'h000000, s_r.period[15:8]};
            if (wr) begin
                s_nxt.period[15:8] = pwdata[7:0];
            end
        end else if (idx == `TDM_IDX_PERIOD2) begin
            rd = {24'h000000, s_r.period[23:16]};
            if (wr) begin
                s_nxt.period[23:16] = pwdata[7:0];
            end
        end else if (idx == `TDM_IDX_STATUS) begin
            rd = {30'h00000000, s_r.syncEn & s_r.syncNext, flagIf.flag};
        end else if (idx == `TDM_IDX_IRQ_STAT) begin
            rd = {28'h0000000, s_r.irqStat};
            if (wr) begin
                clr = pwdata[3:0];
            end
        end else if (idx == `TDM_IDX_IRQ_MASK) begin
            rd = {28'h0000000, s_r.irqMask};
            if (wr) begin
                s_nxt.irqMask = pwdata[3:0];
            end
        end else if (idx == `TDM_IDX_SYSREF_RX) begin
            rd = {31'h00000000, s_r.rxEn};
            if (wr) begin
                s_nxt.rxEn = pwdata[0];
            end
        end else if (idx == `TDM_IDX_PEAK) begin
            rd = {19'h00000, s_r.peakResult};
        end else begin
            hit = 1'b0;
        end

        // One wait state: pready and read data come from flops
        s_nxt.ready = access;
        if (access) begin
            s_nxt.rdata = (hit && !pwrite) ? rd : 32'h00000000;
            s_nxt.slverr = ~hit;
        end

        // Only sys2 reads the first synchroniser stage
        s_nxt.sys1 = sysrefIn;
        s_nxt.sys2 = s_r.sys1;
        s_nxt.sysPrev = s_r.sys2;

        // The receiver gate keeps a floating SYSREF from moving the period
        if (s_r.rxEn && s_r.syncEn && edgeSeen) begin
            s_nxt.periodCnt = 24'h000000;
            s_nxt.peak = 13'h0000;
            ev[`TDM_EV_SYNC] = 1'b1;
            if (s_r.syncNext) begin
                s_nxt.syncEn = 1'b0;
            end
        end else if (s_r.periodCnt + 24'h000001 >= s_r.period) begin
            s_nxt.periodCnt = 24'h000000;
            ev[`TDM_EV_PERIOD] = 1'b1;
            if (s_r.peakEn) begin
                s_nxt.peakResult = s_r.peak;
            end
            s_nxt.peak = 13'h0000;
        end else begin
            s_nxt.periodCnt = s_r.periodCnt + 24'h000001;
        end

        if (!s_r.peakEn) begin
            s_nxt.peak = 13'h0000;
        end else if (sampleMag > s_nxt.peak) begin
            s_nxt.peak = sampleMag;
        end

        ev[`TDM_EV_RISE] = flagIf.rise;
        ev[`TDM_EV_FALL] = flagIf.fall;
        // A new event outweighs a clear in the same cycle
        s_nxt.irqStat = (s_r.irqStat & ~clr) | ev;
        s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqMask);

        s_nxt.pinFirst = s_r.forceEn ? s_r.forceVal : (s_r.flagEn & flagIf.flag);
        s_nxt.pinSecond = s_nxt.pinFirst;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_r <= '0;
            s_r.period <= `TDM_PERIOD_RST;
            s_r.upThr <= `TDM_THR_RST;
            s_r.lowThr <= `TDM_THR_RST;
            s_r.dwell <= `TDM_DWELL_RST;
            s_r.irqMask <= `TDM_IRQ_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.rdata;
    assign pready = s_r.ready;
    assign pslverr = s_r.slverr;
    assign amplitudeFlagPinFirst = s_r.pinFirst;
    assign amplitudeFlagPinSecond = s_r.pinSecond;
    assign irq = s_r.irq;

    a_pin_forced: assert property (@(posedge clk) disable iff (reset)
        s_r.forceEn |=> amplitudeFlagPinFirst == $past(s_r.forceVal))
        else $error("forced pin level wrong");

    a_pin_gated: assert property (@(posedge clk) disable iff (reset)
        !s_r.forceEn && !s_r.flagEn |=> !amplitudeFlagPinFirst && !amplitudeFlagPinSecond)
        else $error("pin active while flag output disabled");

    a_pin_follow: assert property (@(posedge clk) disable iff (reset)
        !s_r.forceEn && s_r.flagEn |=> amplitudeFlagPinFirst == $past(flagIf.flag))
        else $error("enabled pin does not follow the flag");

    a_pins_equal: assert property (@(posedge clk) disable iff (reset)
        amplitudeFlagPinFirst == amplitudeFlagPinSecond)
        else $error("flag pins disagree");

    a_next_clear: assert property (@(posedge clk) disable iff (reset)
        s_r.rxEn && s_r.syncEn && s_r.syncNext && s_r.sys2 && !s_r.sysPrev
        |=> !s_r.syncEn && s_r.periodCnt == 24'h000000)
        else $error("next-sync edge did not realign and disarm");

    a_cont_keep: assert property (@(posedge clk) disable iff (reset)
        s_r.rxEn && s_r.syncEn && !s_r.syncNext && s_r.sys2 && !s_r.sysPrev && !wr
        |=> s_r.syncEn && s_r.periodCnt == 24'h000000)
        else $error("continuous sync lost enable or alignment");

    a_sync_gate: assert property (@(posedge clk) disable iff (reset)
        !s_r.rxEn && !wr |=> s_r.syncEn == $past(s_r.syncEn))
        else $error("sync enable moved with receiver off");

    a_sync_quiet: assert property (@(posedge clk) disable iff (reset)
        !s_r.syncEn |=> !(s_r.irqStat[`TDM_EV_SYNC] && !$past(s_r.irqStat[`TDM_EV_SYNC])))
        else $error("sync event raised while sync disabled");

    a_sync_off: assert property (@(posedge clk) disable iff (reset)
        !s_r.syncEn && s_r.periodCnt + 24'h000001 < s_r.period
        |=> s_r.periodCnt == $past(s_r.periodCnt) + 24'h000001)
        else $error("period counter moved while sync disabled");

    a_peak_off: assert property (@(posedge clk) disable iff (reset)
        !s_r.peakEn |=> s_r.peak == 13'h0000)
        else $error("peak tracked while detector disabled");

    a_peak_hold: assert property (@(posedge clk) disable iff (reset)
        !s_r.peakEn |=> s_r.peakResult == $past(s_r.peakResult))
        else $error("peak result moved while detector disabled");

    a_peak_track: assert property (@(posedge clk) disable iff (reset)
        s_r.peakEn && sampleMag > s_r.peak |=> s_r.peak == $past(sampleMag))
        else $error("peak missed a larger sample");

    a_period_wrap: assert property (@(posedge clk) disable iff (reset)
        !(s_r.rxEn && s_r.syncEn) && s_r.periodCnt + 24'h000001 == s_r.period
        |=> s_r.periodCnt == 24'h000000 && s_r.irqStat[`TDM_EV_PERIOD])
        else $error("period did not wrap at programmed length");

    a_low_write: assert property (@(posedge clk) disable iff (reset)
        wr && idx == `TDM_IDX_LOW_LOW |=> s_r.lowThr[7:0] == $past(pwdata[7:0]))
        else $error("lower threshold low byte not written");

    a_low_high_write: assert property (@(posedge clk) disable iff (reset)
        wr && idx == `TDM_IDX_LOW_HIGH |=> s_r.lowThr[12:8] == $past(pwdata[4:0]))
        else $error("lower threshold high field not written");

    a_upper_write: assert property (@(posedge clk) disable iff (reset)
        wr && idx == `TDM_IDX_UP_HIGH |=> s_r.upThr[12:8] == $past(pwdata[4:0]))
        else $error("upper threshold high field not written");

    a_dwell_write: assert property (@(posedge clk) disable iff (reset)
        wr && idx == `TDM_IDX_DWELL_HIGH |=> s_r.dwell[15:8] == $past(pwdata[7:0]))
        else $error("dwell high byte not written");

    a_peak_write: assert property (@(posedge clk) disable iff (reset)
        wr && idx == `TDM_IDX_MON_CTRL |=> s_r.peakEn == $past(pwdata[`TDM_MC_PEAK_EN]))
        else $error("peak enable not written");

    a_period_write: assert property (@(posedge clk) disable iff (reset)
        wr && idx == `TDM_IDX_PERIOD0 |=> s_r.period[7:0] == $past(pwdata[7:0]))
        else $error("period low byte not written");

    a_rise_sticky: assert property (@(posedge clk) disable iff (reset)
        flagIf.rise |=> s_r.irqStat[`TDM_EV_RISE])
        else $error("flag rise event lost");

    a_irq_level: assert property (@(posedge clk) disable iff (reset)
        irq == |(s_r.irqStat & s_r.irqMask))
        else $error("interrupt level disagrees with masked status");

    a_ready_pulse: assert property (@(posedge clk) disable iff (reset)
        pready |=> !pready)
        else $error("apb ready held longer than one cycle");

    a_error_data: assert property (@(posedge clk) disable iff (reset)
        pready && pslverr |-> prdata == 32'h00000000)
        else $error("apb error answer carried data");

    a_apb_wait: assert property (@(posedge clk) disable iff (reset)
        psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");

endmodule : tdm_monitor_top

// File: verification/tdm_agc_model.sv
/*
 Far-side gain-control logic: drives the fine magnitude and the SYSREF pin,
 and has the flag pins as inputs that no logic reads. Assumes callers enter tasks just after a clk edge.
*/
module tdm_agc_model (
    input wire logic clk,
    output logic [12:0] sampleMag,
    output logic sysrefIn,
    input wire logic amplitudeFlagPinFirst,
    input wire logic amplitudeFlagPinSecond
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sampleMag = 13'h0000;
        sysrefIn = 1'b0;
    end

    task automatic set_mag(input logic [12:0] m);
        @(posedge clk);
        sampleMag <= m;
    endtask : set_mag

    // Gap is a multiple of the monitor period so continuous mode stays aligned
    task automatic sysref_pulse(input int gap);
        repeat (gap) @(posedge clk);
        sysrefIn <= 1'b1;
        repeat (3) @(posedge clk);
        sysrefIn <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : sysref_pulse
endmodule : tdm_agc_model

// File: verification/threshold_dwell_monitor_sync_tb.sv
/*
 Self-checking bench of the flag, dwell and monitor block over APB.
 Assumes each access is answered within 20 cycles.
*/
`include "tdm_regs.svh"

module threshold_dwell_monitor_sync_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [12:0] sampleMag;
    logic sysrefIn;
    logic pinFirst;
    logic pinSecond;
    logic irq;
    int errorCnt = 0;
    int nTests = 0;
    logic [9:0] regIdx [0:8] = '{`TDM_IDX_UP_LOW, `TDM_IDX_UP_HIGH, `TDM_IDX_LOW_LOW,
        `TDM_IDX_LOW_HIGH, `TDM_IDX_DWELL_LOW, `TDM_IDX_DWELL_HIGH, `TDM_IDX_SYNC_CTRL,
        `TDM_IDX_MON_CTRL, `TDM_IDX_PERIOD0};
    logic [7:0] rstVal [0:8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h80};
    logic [7:0] rwMask [0:8] = '{8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h03,
        8'h02, 8'hFF};
    logic [7:0] rxT [0:5] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    logic [7:0] ctlT [0:5] = '{8'h01, 8'h00, 8'h03, 8'h02, 8'h01, 8'h01};
    logic [7:0] expCtl [0:5] = '{8'h01, 8'h00, 8'h02, 8'h02, 8'h01, 8'h01};
    logic [7:0] expBit [0:5] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h04, 8'h04};

    always #5 clk = ~clk;

    tdm_monitor_top tdm_monitor_top_inst (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sampleMag(sampleMag),
        .sysrefIn(sysrefIn), .amplitudeFlagPinFirst(pinFirst),
        .amplitudeFlagPinSecond(pinSecond), .irq(irq));

    tdm_agc_model tdm_agc_model_inst (.clk(clk), .sampleMag(sampleMag),
        .sysrefIn(sysrefIn), .amplitudeFlagPinFirst(pinFirst),
        .amplitudeFlagPinSecond(pinSecond));

    task endSim;
        $display("Counts: %0d checks, %0d mismatches", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : endSim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
             output logic [31:0] rd, output logic err);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            errorCnt++;
            endSim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, idx, d, rd, err);
    endtask : wr

    task rdc(input logic [9:0] idx, input logic [31:0] exp, input logic [31:0] msk);
        logic [31:0] rd;
        logic err;
        apb(1'b0, idx, 8'h00, rd, err);
        chk(rd & msk, exp);
    endtask : rdc

    // Value read at an edge is the one settled during the cycle before it
    task pins(input logic v);
        @(posedge clk);
        chk({pinFirst, pinSecond}, {v, v});
    endtask : pins

    initial begin
        logic [31:0] rd;
        logic err;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 9; i++) begin
            rdc(regIdx[i], rstVal[i], 32'hFFFFFFFF);
            wr(regIdx[i], 8'hFF);
            rdc(regIdx[i], rwMask[i], 32'hFFFFFFFF);
            wr(regIdx[i], rstVal[i]);
        end
        apb(1'b0, 10'h3FF, 8'h00, rd, err);
        chk(err, 1);
        chk(rd, 0);
        $display("Test done: registers");
        wr(`TDM_IDX_UP_LOW, 8'h64);
        wr(`TDM_IDX_LOW_LOW, 8'h32);
        wr(`TDM_IDX_DWELL_LOW, 8'h03);
        wr(`TDM_IDX_FLAG_CTRL, 8'h01);
        tdm_agc_model_inst.set_mag(13'h00C8);
        repeat (2) @(posedge clk);
        pins(1'b1);
        tdm_agc_model_inst.set_mag(13'h000A);
        repeat (3) @(posedge clk);
        pins(1'b1);
        repeat (2) @(posedge clk);
        pins(1'b0);
        rdc(`TDM_IDX_IRQ_STAT, 32'h3, 32'h3);
        chk(irq, 0);
        wr(`TDM_IDX_IRQ_MASK, 8'h03);
        chk(irq, 1);
        wr(`TDM_IDX_IRQ_STAT, 8'h03);
        rdc(`TDM_IDX_IRQ_STAT, 32'h0, 32'h3);
        chk(irq, 0);
        tdm_agc_model_inst.set_mag(13'h00C8);
        tdm_agc_model_inst.set_mag(13'h000A);
        // Two cycles below a dwell of 3, then back between the thresholds
        repeat (1) @(posedge clk);
        tdm_agc_model_inst.set_mag(13'h003C);
        repeat (6) @(posedge clk);
        pins(1'b1);
        wr(`TDM_IDX_DWELL_LOW, 8'h00);
        wr(`TDM_IDX_DWELL_HIGH, 8'h01);
        tdm_agc_model_inst.set_mag(13'h00C8);
        tdm_agc_model_inst.set_mag(13'h000A);
        repeat (250) @(posedge clk);
        pins(1'b1);
        repeat (10) @(posedge clk);
        pins(1'b0);
        wr(`TDM_IDX_FLAG_CTRL, 8'h0C);
        pins(1'b1);
        wr(`TDM_IDX_FLAG_CTRL, 8'h00);
        tdm_agc_model_inst.set_mag(13'h00C8);
        repeat (3) @(posedge clk);
        pins(1'b0);
        rdc(`TDM_IDX_STATUS, 32'h1, 32'hFFFFFFFF);
        $display("Test done: flag and dwell");
        wr(`TDM_IDX_PERIOD0, 8'h10);
        wr(`TDM_IDX_MON_CTRL, 8'h02);
        tdm_agc_model_inst.set_mag(13'h004D);
        repeat (40) @(posedge clk);
        rdc(`TDM_IDX_PEAK, 32'h4D, 32'h1FFF);
        wr(`TDM_IDX_MON_CTRL, 8'h00);
        tdm_agc_model_inst.set_mag(13'h005A);
        repeat (40) @(posedge clk);
        rdc(`TDM_IDX_PEAK, 32'h4D, 32'h1FFF);
        $display("Test done: peak detector");
        wr(`TDM_IDX_IRQ_MASK, 8'h04);
        for (int i = 0; i < 6; i++) begin
            wr(`TDM_IDX_SYSREF_RX, rxT[i]);
            wr(`TDM_IDX_SYNC_CTRL, ctlT[i]);
            wr(`TDM_IDX_IRQ_STAT, 8'h04);
            tdm_agc_model_inst.sysref_pulse(128);
            rdc(`TDM_IDX_SYNC_CTRL, {24'h0, expCtl[i]}, 32'hFF);
            rdc(`TDM_IDX_IRQ_STAT, {24'h0, expBit[i]}, 32'h4);
            chk(irq, expBit[i] != 8'h00);
        end
        $display("Test done: monitor sync");
        endSim();
    end
endmodule : threshold_dwell_monitor_sync_tb
